// ===== temp_result_core.sv
// Result storage, limit checks and register file of the monitor.
// Assumes a front end that converts on request and a byte-level
// bus engine on the link clock that issues register accesses.
`timescale 1ns/1ps
`include "temp_result_params.svh"
module temp_result_core
    import temp_result_pkg::*;
(
    // Internal clock and control
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // Analog front end
    output logic CONV_START_O,
    output logic [1:0] CONV_CHAN_O,
    input wire logic MEAS_VALID_I,
    input wire logic signed [11:0] MEAS_TEMP_I,
    input wire logic [1:0] DIODE_OPEN_I,
    // Open-drain pins, enable high pulls low
    output logic ALARM_OUT_N_O,
    output logic ALARM_OUT_N_OE_O,
    output logic OVERTEMP_OUT_N_O,
    output logic OVERTEMP_OUT_N_OE_O,
    // Register access on the link clock
    input wire logic LINK_CLK_I,
    input wire logic LINK_REQ_I,
    input wire logic LINK_WE_I,
    input wire logic [7:0] LINK_ADDR_I,
    input wire logic [7:0] LINK_WDATA_I,
    output logic LINK_READY_O,
    output logic LINK_RVALID_O,
    output logic [7:0] LINK_RDATA_O
);
    core_state_t s_q, s_d; // Internal-clock state
    link_state_t l_q, l_d; // Link-clock state
    logic [2:0][7:0] result; // Live high bytes per channel
    logic [2:0] high_hit, low_hit, over_hit; // Comparison outcomes
    logic [7:0] status_d; // Alarm-side status flags
    logic req_edge; // One access handed over
    logic ext_range; // Extended range in force
    logic avg_on; // Averaging wanted at this rate

    // Raw quarter degrees to {high byte, two fraction bits}
    function automatic logic [9:0] fmt_temp(input logic signed [11:0] raw,
                                            input logic ext);
        logic signed [9:0] whole;
        logic signed [10:0] shifted;
        whole = raw[11:2];
        shifted = {whole[9], whole} + `EXT_OFFSET;
        if (ext) begin
            // Clamp rather than wrap at both ends
            if (shifted < 0) fmt_temp = 10'h000;
            else if (shifted > `EXT_MAX_INT) fmt_temp = {`CODE_MAX, 2'b11};
            else fmt_temp = {shifted[7:0], raw[1:0]};
        end else begin
            // Below zero reads zero, above 127 reads 127
            if (whole < 0) fmt_temp = 10'h000;
            else if (whole > `PLAIN_MAX_INT) fmt_temp = {`PLAIN_MAX, 2'b00};
            else fmt_temp = {whole[7:0], raw[1:0]};
        end
    endfunction

    // Register read decode, shared by the access path
    function automatic logic [7:0] read_reg(input core_state_t s,
                                            input logic [7:0] addr);
        logic sw;
        sw = s.cfg[`CFG_SWAP];
        read_reg = 8'h00; // Unmapped reads as zero
        unique case (addr)
            `ADDR_LOCAL: read_reg = s.local_val;
            // Swap bit steers the remote one addresses
            `ADDR_R1_HIGH: read_reg = s.held_hi[sw];
            `ADDR_R1_LOW: read_reg = {s.live_lo[sw], 6'h00};
            `ADDR_R2_HIGH: read_reg = s.held_hi[1];
            `ADDR_R2_LOW: read_reg = {s.live_lo[1], 6'h00};
            `ADDR_STATUS: read_reg = s.status;
            `ADDR_STATUS2: read_reg = {5'h00, s.over};
            `ADDR_CFG_RD: read_reg = s.cfg;
            `ADDR_RATE_RD: read_reg = {4'h0, s.rate};
            default: begin
                for (int c = 0; c < 3; c++) begin
                    for (int k = 0; k < 3; k++) begin
                        if (addr == `ADDR_LIMIT_BASE + 8'(c * 3 + k))
                            read_reg = s.limit[c][k];
                    end
                end
            end
        endcase
    endfunction

    // Limit comparisons on the live results, in the current format
    always_comb begin
        result[0] = s_q.local_val;
        result[1] = s_q.live_hi[0];
        result[2] = s_q.live_hi[1];
        for (int c = 0; c < 3; c++) begin
            high_hit[c] = result[c] > s_q.limit[c][0];
            low_hit[c] = result[c] < s_q.limit[c][1];
            over_hit[c] = result[c] > s_q.limit[c][2];
        end
        status_d = {DIODE_OPEN_I[1], low_hit[2], high_hit[2],
                    DIODE_OPEN_I[0], low_hit[1], high_hit[1],
                    low_hit[0], high_hit[0]};
        ext_range = s_q.cfg[`CFG_RANGE];
        avg_on = s_q.rate < `RATE_FAST_MIN;
        req_edge = s_q.req_s2 != s_q.req_prev;
    end

    // Next state of the internal-clock side
    always_comb begin
        logic [9:0] code;
        logic [15:0] acc_new;
        logic [1:0] ch;
        logic [7:0] ra;
        logic masked;
        code = 10'h000;
        acc_new = 16'h0000;
        ch = s_q.chan;
        ra = l_q.addr;
        masked = 1'b0;
        s_d = s_q;
        s_d.conv_start = 1'b0;
        // Request toggle crosses in; first stage feeds only the second
        s_d.req_s1 = l_q.req_tgl;
        s_d.req_s2 = s_q.req_s1;
        s_d.req_prev = s_q.req_s2;

        // Measurement sequencer
        unique case (s_q.seq)
            SEQ_IDLE: begin
                // Standby holds off new conversions only
                if (!s_q.cfg[`CFG_STANDBY]) begin
                    s_d.conv_start = 1'b1;
                    s_d.conv_chan = ch;
                    s_d.seq = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (MEAS_VALID_I) begin
                    acc_new = s_q.acc[ch] + 16'(MEAS_TEMP_I);
                    if (avg_on) begin
                        // Sum sixteen cycles, then store the mean
                        s_d.acc[ch] = acc_new;
                        if (s_q.avg_cnt == `AVG_LAST) begin
                            code = fmt_temp(acc_new[15:`AVG_SHIFT],
                                            ext_range);
                            s_d.acc[ch] = 16'h0000;
                        end
                    end else begin
                        // Fast rates store every conversion as is
                        code = fmt_temp(MEAS_TEMP_I, ext_range);
                        s_d.acc[ch] = 16'h0000;
                    end
                    // Format follows the range at store time
                    if (!avg_on || s_q.avg_cnt == `AVG_LAST) begin
                        if (ch == 2'd0) s_d.local_val = code[9:2];
                        else begin
                            // Remote: 8 high bits, 2 low bits
                            s_d.live_hi[ch - 2'd1] = code[9:2];
                            s_d.live_lo[ch - 2'd1] = code[1:0];
                        end
                    end
                    // Round robin over the three channels
                    if (ch == 2'd2) begin
                        s_d.chan = 2'd0;
                        s_d.avg_cnt = avg_on ? s_q.avg_cnt + 4'd1 : 4'd0;
                    end else begin
                        s_d.chan = ch + 2'd1;
                    end
                    s_d.seq = SEQ_IDLE;
                end
            end
        endcase

        // One register access per handed-over request
        if (req_edge) begin
            s_d.ack_tgl = ~s_q.ack_tgl;
            if (l_q.we) begin
                if (ra == `ADDR_CFG_WR)
                    s_d.cfg = l_q.wdata & `CFG_WR_MASK;
                else if (ra == `ADDR_RATE_WR)
                    s_d.rate = l_q.wdata[3:0];
                // Limits only change by host write
                for (int c = 0; c < 3; c++) begin
                    for (int k = 0; k < 3; k++) begin
                        if (ra == `ADDR_LIMIT_BASE + 8'(c * 3 + k))
                            s_d.limit[c][k] = l_q.wdata;
                    end
                end
            end else begin
                s_d.rdata = read_reg(s_q, ra);
                // Low byte read locks its high byte
                if (ra == `ADDR_R1_LOW)
                    s_d.lock[s_q.cfg[`CFG_SWAP]] = 1'b1;
                if (ra == `ADDR_R2_LOW) s_d.lock[1] = 1'b1;
                if (ra == `ADDR_R1_HIGH)
                    s_d.lock[s_q.cfg[`CFG_SWAP]] = 1'b0;
                if (ra == `ADDR_R2_HIGH) s_d.lock[1] = 1'b0;
            end
        end

        // Unlocked high bytes follow the live results; a lock set this
        // cycle keeps the byte paired with the low byte just read
        for (int r = 0; r < 2; r++) begin
            if (!s_d.lock[r]) s_d.held_hi[r] = s_d.live_hi[r];
        end

        // Flags and pins track limits even in standby
        s_d.status = status_d;
        s_d.over = over_hit;
        masked = |{status_d[7], status_d[6:5] &
                   {2{~s_q.cfg[`CFG_MASK_R2]}},
                   status_d[4], status_d[3:2] &
                   {2{~s_q.cfg[`CFG_MASK_R1]}},
                   status_d[1:0]};
        if (s_q.cfg[`CFG_PIN_OVERTEMP])
            s_d.alarm_oe = |over_hit; // Second overtemp pin
        else
            s_d.alarm_oe = masked && !s_q.cfg[`CFG_ALARM_MASK];
        s_d.overtemp_oe = |over_hit;
    end

    // Internal-clock registers; clock enable freezes everything
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
            s_q.rate <= `RATE_RST;
            s_q.cfg <= `CFG_RST;
            for (int c = 0; c < 3; c++) begin
                s_q.limit[c][0] <= `LIMIT_HIGH_RST;
                s_q.limit[c][1] <= `LIMIT_LOW_RST;
                s_q.limit[c][2] <= `LIMIT_OVER_RST;
            end
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    // Link side: hold the request stable until the answer returns
    always_comb begin
        l_d = l_q;
        l_d.rvalid = 1'b0;
        // Answer toggle crosses back through two stages
        l_d.ack_s1 = s_q.ack_tgl;
        l_d.ack_s2 = l_q.ack_s1;
        l_d.ack_prev = l_q.ack_s2;
        if (!l_q.busy && LINK_REQ_I) begin
            // Fields stay put while busy, so the core sees them settled
            l_d.we = LINK_WE_I;
            l_d.addr = LINK_ADDR_I;
            l_d.wdata = LINK_WDATA_I;
            l_d.req_tgl = ~l_q.req_tgl;
            l_d.busy = 1'b1;
        end else if (l_q.busy && l_q.ack_s2 != l_q.ack_prev) begin
            l_d.busy = 1'b0;
            l_d.rdata = s_q.rdata; // Stable since the toggle
            l_d.rvalid = !l_q.we;
        end
        l_d.ready = !l_d.busy;
    end

    // Link-clock registers
    always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            l_q <= '0;
            l_q.ready <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    // Outputs straight from flip-flops; pin data tied low
    assign CONV_START_O = s_q.conv_start;
    assign CONV_CHAN_O = s_q.conv_chan;
    assign ALARM_OUT_N_O = 1'b0;
    assign ALARM_OUT_N_OE_O = s_q.alarm_oe;
    assign OVERTEMP_OUT_N_O = 1'b0;
    assign OVERTEMP_OUT_N_OE_O = s_q.overtemp_oe;
    assign LINK_READY_O = l_q.ready;
    assign LINK_RVALID_O = l_q.rvalid;
    assign LINK_RDATA_O = l_q.rdata;

    // Conversion start seen, then low again the next cycle
    sequence start_seen_s;
        CONV_START_O;
    endsequence
    sequence back_idle_s;
        !CONV_START_O;
    endsequence

    start_pulse_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        start_seen_s |=> back_idle_s)
        else $error("Conversion start lasted over one cycle");

    standby_quiet_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        $rose(CONV_START_O) |-> !$past(s_q.cfg[`CFG_STANDBY]))
        else $error("Conversion started in standby");

    alarm_level_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        CE_I && !s_q.cfg[`CFG_PIN_OVERTEMP] && !s_q.cfg[`CFG_ALARM_MASK]
        && (high_hit[0] || low_hit[0] || |DIODE_OPEN_I)
        |=> ALARM_OUT_N_OE_O)
        else $error("Alarm pin not pulled low on breach");

    overtemp_level_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        CE_I |=> OVERTEMP_OUT_N_OE_O == $past(|over_hit))
        else $error("Overtemp pin does not follow limit");

    pin_overtemp_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        CE_I && s_q.cfg[`CFG_PIN_OVERTEMP]
        |=> ALARM_OUT_N_OE_O == $past(|over_hit))
        else $error("Alarm pin not acting as overtemp");

    lock_hold_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        s_q.lock[0] && $past(s_q.lock[0]) |-> $stable(s_q.held_hi[0]))
        else $error("Locked high byte changed");

    low_byte_zero_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        CE_I && req_edge && !l_q.we && l_q.addr == `ADDR_R2_LOW
        |=> s_q.rdata[5:0] == 6'h00)
        else $error("Low byte unused bits not zero");

    plain_clamp_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        CE_I && MEAS_VALID_I && s_q.seq == SEQ_WAIT && !avg_on
        && !ext_range && s_q.chan == 2'd0 && MEAS_TEMP_I < 0
        |=> s_q.local_val == 8'h00)
        else $error("Plain format below zero not clamped");

    link_answer_a: assert property (
        @(posedge LINK_CLK_I) disable iff (RST_I)
        LINK_RVALID_O |-> LINK_READY_O ##1 !LINK_RVALID_O)
        else $error("Read answer not a single pulse");

    // A register read or write reaching the core this cycle
    sequence read_taken_s;
        CE_I && req_edge && !l_q.we;
    endsequence
    sequence write_taken_s;
        CE_I && req_edge && l_q.we;
    endsequence

    lock_set_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        read_taken_s ##0 l_q.addr == `ADDR_R2_LOW
        |=> s_q.lock[1])
        else $error("Low byte read left high byte free");

    lock_clear_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        read_taken_s ##0 l_q.addr == `ADDR_R2_HIGH
        |=> !s_q.lock[1])
        else $error("High byte read left lock set");

    swap_read_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        read_taken_s ##0 l_q.addr == `ADDR_R1_HIGH ##0 s_q.cfg[`CFG_SWAP]
        |=> s_q.rdata == $past(s_q.held_hi[1]))
        else $error("Swapped read not from remote two");

    cfg_write_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        write_taken_s ##0 l_q.addr == `ADDR_CFG_WR
        |=> s_q.cfg == ($past(l_q.wdata) & `CFG_WR_MASK))
        else $error("Config write not applied");

    range_write_a: assert property (
        @(posedge CLK_I) disable iff (RST_I)
        write_taken_s ##0 l_q.addr == `ADDR_CFG_WR
        |=> ext_range == $past(l_q.wdata[`CFG_RANGE]))
        else $error("Range bit not taken from write");
endmodule

// ===== temp_result_params.svh
// Constants for the three-channel temperature result logic.
// Assumes inclusion by the core module only.
// Summary of operation
// - Converter cycles local, remote one, remote two
// - Each result compared with high, low, overtemp limits
// - Alarm pin low on high or low limit breach or open diode
// - Overtemp pin low above overtemp limit
// - Config bit turns alarm pin into overtemp
// - Host writes limits, config; reads every register
// - Average sixteen cycles unless rate is fast
// - Local result is 8 bits, one degree
// - Remote result 10 bits, high and low byte
// - Results at 0x00, 0x01/0x10, 0x30/0x33
// - Config bit 3 maps remote two onto 0x01/0x10
// - Low byte uses bits 7:6 only, quarter degrees
// - Low byte read freezes high byte until read
// - Config bit 2 selects extended -64 to 191 range
// - New range valid from next measurement cycle
// - Extended range codes are temperature plus 64
// - Plain binary clamps to 0 and 127
// - Range switch leaves limit registers untouched
// - Standby stops conversions, outputs keep updating
// - Config read at 0x03, written at 0x09
`ifndef TEMP_RESULT_PARAMS_SVH
`define TEMP_RESULT_PARAMS_SVH
// Register addresses
`define ADDR_LOCAL 8'h00
`define ADDR_R1_HIGH 8'h01
`define ADDR_R1_LOW 8'h10
`define ADDR_R2_HIGH 8'h30
`define ADDR_R2_LOW 8'h33
`define ADDR_STATUS 8'h02
`define ADDR_STATUS2 8'h23
`define ADDR_CFG_RD 8'h03
`define ADDR_CFG_WR 8'h09
`define ADDR_RATE_RD 8'h04
`define ADDR_RATE_WR 8'h0A
`define ADDR_LIMIT_BASE 8'h40
// Configuration bit positions
`define CFG_ALARM_MASK 7
`define CFG_STANDBY 6
`define CFG_PIN_OVERTEMP 5
`define CFG_SWAP 3
`define CFG_RANGE 2
`define CFG_MASK_R1 1
`define CFG_MASK_R2 0
`define CFG_WR_MASK 8'hEF
// Reset values
`define CFG_RST 8'h00
`define RATE_RST 4'h8
`define LIMIT_HIGH_RST 8'h7F
`define LIMIT_LOW_RST 8'h00
`define LIMIT_OVER_RST 8'h7F
// Averaging and formatting
`define AVG_LAST 4'hF
`define AVG_SHIFT 4
`define RATE_FAST_MIN 4'h8
`define EXT_OFFSET 11'sh040
`define PLAIN_MAX 8'h7F
`define CODE_MAX 8'hFF
`define PLAIN_MAX_INT 10'sh07F
`define EXT_MAX_INT 11'sh0FF
`endif

// ===== temp_result_pkg.sv
// Types shared by the temperature result logic.
// Assumes the constants header sits in the include path.
package temp_result_pkg;
    // Measurement sequencer states
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_WAIT = 1'b1
    } seq_state_t;

    // State of the internal-clock side
    typedef struct packed {
        seq_state_t seq;
        logic [1:0] chan;
        logic [3:0] avg_cnt;
        logic [2:0][15:0] acc;
        logic [7:0] local_val;
        logic [1:0][7:0] live_hi;
        logic [1:0][1:0] live_lo;
        logic [1:0][7:0] held_hi;
        logic [1:0] lock;
        logic [7:0] cfg;
        logic [3:0] rate;
        logic [2:0][2:0][7:0] limit;
        logic [7:0] status;
        logic [2:0] over;
        logic conv_start;
        logic [1:0] conv_chan;
        logic alarm_oe;
        logic overtemp_oe;
        logic req_s1;
        logic req_s2;
        logic req_prev;
        logic ack_tgl;
        logic [7:0] rdata;
    } core_state_t;

    // State of the link-clock side
    typedef struct packed {
        logic req_tgl;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic ack_s1;
        logic ack_s2;
        logic ack_prev;
        logic busy;
        logic ready;
        logic rvalid;
        logic [7:0] rdata;
    } link_state_t;
endpackage

// ===== temp_frontend_model.sv
// Behavioural converter front end answering conversion requests.
// Assumes one request at a time, raised for a single clock cycle.
`timescale 1ns/1ps
module temp_frontend_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request from the sequencer
    input wire logic start_i,
    input wire logic [1:0] chan_i,
    // Temperatures to report, quarter degrees
    input wire logic signed [11:0] temp0_i,
    input wire logic signed [11:0] temp1_i,
    input wire logic signed [11:0] temp2_i,
    // Slow answers and local jitter
    input wire logic slow_i,
    input wire logic jit_i,
    // Result back to the block
    output logic valid_o,
    output logic signed [11:0] temp_o
);
    logic [3:0] cnt_q; // Cycles left, zero when idle
    logic [1:0] chan_q; // Channel in conversion
    logic odd_q; // Toggles on every local sample
    logic signed [11:0] val; // Value for this channel
    // Jitter swings local by two degrees, so only a true average
    // lands on the midpoint
    always_comb begin
        case (chan_q)
            2'd1: val = temp1_i;
            2'd2: val = temp2_i;
            default: val = temp0_i + ((jit_i && odd_q) ? 12'sd8 : 12'sd0);
        endcase
    end
    // Count down, then pulse; the data bus churns outside the pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            chan_q <= 2'd0;
            odd_q <= 1'b0;
            valid_o <= 1'b0;
            temp_o <= 12'h000;
        end else begin
            valid_o <= 1'b0;
            temp_o <= ~temp_o;
            if (start_i) begin
                cnt_q <= slow_i ? 4'h7 : 4'h2;
                chan_q <= chan_i;
            end else if (cnt_q == 4'h1) begin
                cnt_q <= 4'h0;
                valid_o <= 1'b1;
                temp_o <= val;
                odd_q <= odd_q ^ (chan_q == 2'd0);
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

// ===== triple_channel_temp_result_logic_tb_top.sv
// Self-checking bench for the temperature result logic.
// Assumes the core, its package and the front-end model compile first.
`timescale 1ns/1ps
module triple_channel_temp_result_logic_tb_top;
    logic clk = 1'b0; // Internal clock
    logic lclk = 1'b0; // Link clock
    logic rst = 1'b1; // Reset, both domains
    logic req = 1'b0; // Link request
    logic we = 1'b0; // Link write
    logic [7:0] addr = 8'h00; // Link address
    logic [7:0] wdata = 8'h00; // Link write data
    logic [1:0] diode = 2'b00; // Open diode flags
    logic slow = 1'b0; // Slow converter answers
    logic jit = 1'b0; // Local jitter on
    logic signed [11:0] t0 = 12'hFEC; // Local, minus five
    logic signed [11:0] t1 = 12'h0C9; // Remote one, 50.25
    logic signed [11:0] t2 = 12'h320; // Remote two, 200
    logic start, valid, ready, rvalid, aoe, toe, a_n, t_n;
    logic [1:0] cchan;
    logic signed [11:0] mtemp;
    logic [7:0] rdata;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0; // Timeout counter
    int starts = 0; // Conversion requests seen
    // Clocks, phases unrelated
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    // Hang guard and start counter
    always @(negedge clk) begin
        cyc <= cyc + 1;
        if (start === 1'b1) begin
            starts <= starts + 1;
        end
        if (cyc == 30000) begin
            err_total++;
            give_verdict;
        end
    end
    temp_result_core u_temp_result_core (
        .CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .CONV_START_O(start), .CONV_CHAN_O(cchan),
        .MEAS_VALID_I(valid), .MEAS_TEMP_I(mtemp), .DIODE_OPEN_I(diode),
        .ALARM_OUT_N_O(a_n), .ALARM_OUT_N_OE_O(aoe),
        .OVERTEMP_OUT_N_O(t_n), .OVERTEMP_OUT_N_OE_O(toe),
        .LINK_CLK_I(lclk), .LINK_REQ_I(req), .LINK_WE_I(we),
        .LINK_ADDR_I(addr), .LINK_WDATA_I(wdata), .LINK_READY_O(ready),
        .LINK_RVALID_O(rvalid), .LINK_RDATA_O(rdata));
    temp_frontend_model u_temp_frontend_model (
        .clk_i(clk), .rst_i(rst), .start_i(start), .chan_i(cchan),
        .temp0_i(t0), .temp1_i(t1), .temp2_i(t2), .slow_i(slow),
        .jit_i(jit), .valid_o(valid), .temp_o(mtemp));
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One link access; request held until taken, then released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        // Settled values are looked at on the falling edge
        @(negedge lclk);
        while (ready !== 1'b1 && n < 40) begin
            @(negedge lclk);
            n++;
        end
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        @(posedge lclk); // Taken here, ready stood high
        @(negedge lclk);
        req = 1'b0;
        addr = ~a;
        wdata = ~d;
        // Busy first, then ready again with data for reads
        while (!(ready === 1'b1 && (w || rvalid === 1'b1)) && n < 40) begin
            @(negedge lclk);
            n++;
        end
        q = rdata;
        if (n >= 40) begin
            err_total++;
            $display("BAD %0t link stuck at %h", $time, a);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk(q, exp, $sformatf("read %h", a));
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Reset values and an unmapped place
    task automatic t_reset;
        rdc(8'h03, 8'h00);
        rdc(8'h40, 8'h7F);
        rdc(8'h41, 8'h00);
        rdc(8'h7E, 8'h00);
        $display("test reset done");
    endtask
    // Plain format, clamps at both ends
    task automatic t_plain;
        pause(100);
        rdc(8'h00, 8'h00);
        rdc(8'h10, 8'h40);
        rdc(8'h01, 8'h32);
        rdc(8'h33, 8'h00);
        rdc(8'h30, 8'h7F);
        $display("test plain done");
    endtask
    // Channel swap on the first remote addresses
    task automatic t_swap;
        wr(8'h09, 8'h08);
        rdc(8'h10, 8'h00);
        rdc(8'h01, 8'h7F);
        wr(8'h09, 8'h00);
        rdc(8'h10, 8'h40);
        rdc(8'h01, 8'h32);
        $display("test swap done");
    endtask
    // Low byte read freezes the high byte across new results
    task automatic t_lock;
        rdc(8'h10, 8'h40);
        t1 = 12'h0F2;
        pause(100);
        rdc(8'h01, 8'h32);
        rdc(8'h01, 8'h3C);
        rdc(8'h10, 8'h80);
        rdc(8'h01, 8'h3C);
        $display("test lock done");
    endtask
    // Extended range, offset codes and clamps, limits kept
    task automatic t_ext;
        wr(8'h09, 8'h04);
        pause(40);
        rdc(8'h00, 8'h3B);
        rdc(8'h10, 8'h80);
        rdc(8'h01, 8'h7C);
        rdc(8'h33, 8'hC0);
        rdc(8'h30, 8'hFF);
        t1 = 12'hEE8;
        pause(100);
        rdc(8'h10, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h40, 8'h7F);
        wr(8'h09, 8'h00);
        pause(40);
        rdc(8'h01, 8'h00);
        t1 = 12'h0F2;
        $display("test ext done");
    endtask
    // Flags and pins follow limits, pin function and open diode
    task automatic t_alarm;
        t0 = 12'h078;
        wr(8'h40, 8'h14);
        pause(40);
        chk({7'h00, aoe}, 8'h01, "alarm on");
        rdc(8'h02, 8'h01);
        wr(8'h42, 8'h14);
        pause(40);
        chk({7'h00, toe}, 8'h01, "overtemp on");
        rdc(8'h23, 8'h01);
        wr(8'h40, 8'h7F);
        pause(40);
        chk({7'h00, aoe}, 8'h00, "alarm off");
        wr(8'h09, 8'h20);
        pause(40);
        chk({7'h00, aoe}, 8'h01, "second overtemp");
        wr(8'h09, 8'h00);
        wr(8'h42, 8'h7F);
        pause(40);
        chk({6'h00, aoe, toe}, 8'h00, "pins off");
        chk({6'h00, a_n, t_n}, 8'h00, "pin data");
        diode = 2'b01;
        pause(40);
        chk({7'h00, aoe}, 8'h01, "open diode");
        rdc(8'h02, 8'h10);
        diode = 2'b00;
        pause(40);
        $display("test alarm done");
    endtask
    // Standby halts conversions, pins still follow limits
    task automatic t_standby;
        int s;
        wr(8'h09, 8'h40);
        pause(20);
        s = starts;
        wr(8'h40, 8'h14);
        pause(40);
        chk({7'h00, aoe}, 8'h01, "standby alarm");
        chk({7'h00, starts == s}, 8'h01, "standby idle");
        wr(8'h40, 8'h7F);
        wr(8'h09, 8'h00);
        pause(40);
        chk({7'h00, starts > s}, 8'h01, "running again");
        $display("test standby done");
    endtask
    // Averaging at rate 7, none at rates 8 to 10
    task automatic t_avg;
        logic [7:0] q;
        jit = 1'b1;
        slow = 1'b1;
        wr(8'h0A, 8'h07);
        pause(1100);
        rdc(8'h00, 8'h1F);
        for (int r = 8; r < 11; r++) begin
            wr(8'h0A, 8'(r));
            rdc(8'h04, 8'(r));
            pause(40);
            xfer(1'b0, 8'h00, 8'h00, q);
            chk({7'h00, q == 8'h1E || q == 8'h20}, 8'h01, "raw");
        end
        $display("test avg done");
    endtask
    // Counts, verdict, end of run
    task automatic give_verdict;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        pause(10);
        rst = 1'b0;
        t_reset;
        t_plain;
        t_swap;
        t_lock;
        t_ext;
        t_alarm;
        t_standby;
        t_avg;
        give_verdict;
    end
endmodule
